// ---- hw/oqpsk_modem.v ----
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "modem_regs.vh"

module oqpsk_modem #(
  parameter SAMPLE_DIV = 12,
  parameter RSSI_WIN_LOG = 3,
  parameter SETTLE_CYCLES = (`RF_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  // Transmit FIFO of the MAC
  input wire [7:0] tx_fifo_data,
  input wire tx_fifo_valid,
  output wire tx_fifo_pop,
  // DAC samples, two's complement
  output reg [7:0] dac_i,
  output reg [7:0] dac_q,
  output reg dac_valid,
  // Demodulator and power from the receive path
  input wire [3:0] demod_sym,
  input wire demod_sym_valid,
  input wire [7:0] rx_power,
  input wire rx_power_valid,
  // Receive FIFO of the MAC
  output reg [7:0] rx_fifo_data,
  output reg rx_fifo_write,
  // RF front end power
  output wire rf_enable
);

  localparam M_IDLE = 3'b001;
  localparam M_WAKE = 3'b010;
  localparam M_READY = 3'b100;
  localparam T_IDLE = 5'b00001;
  localparam T_CCA = 5'b00010;
  localparam T_SEND = 5'b00100;
  localparam T_FETCH = 5'b01000;
  localparam T_DONE = 5'b10000;
  localparam R_HUNT = 3'b001;
  localparam R_LEN = 3'b010;
  localparam R_BODY = 3'b100;

  reg [2:0] mstate;
  reg [15:0] settle;
  reg [4:0] tstate;
  reg [2:0] rstate;
  reg [3:0] flags;
  reg [3:0] mask;
  reg [3:0] snap;
  reg [7:0] cca_thr;
  reg [7:0] rssi_pkt;
  reg [7:0] rssi_live;
  reg pkt_latched;
  reg [RSSI_WIN_LOG+7:0] acc;
  reg [RSSI_WIN_LOG-1:0] wcnt;
  reg [7:0] div;
  reg [2:0] sph;
  reg [4:0] chip_idx;
  reg nib;
  reg [7:0] bcnt;
  reg [7:0] cur_byte;
  reg [6:0] tx_len;
  reg ichip;
  reg qchip;
  reg tx_done_ev;
  reg [3:0] prev_sym;
  reg [3:0] low_nib;
  reg rnib;
  reg [6:0] rx_len;
  reg [6:0] rcnt;
  reg rx_begin_ev;
  reg rx_done_ev;
  reg ready_ev;
  reg [31:0] rdata;
  reg hit;
  reg [2:0] code;

  // Sequence for a symbol: rotate by four chips per step, invert odd chips in upper half
  function [31:0] chip_seq;
    input [3:0] sym;
    reg [63:0] d;
    begin
      d = {`CHIP_BASE, `CHIP_BASE} >> {sym[2:0], 2'h0};
      chip_seq = d[31:0] ^ (sym[3] ? `CHIP_ODD_MASK : 32'h00000000);
    end
  endfunction

  // Half-sine pulse, eight samples across two chip periods
  function [7:0] shape;
    input chip;
    input [2:0] ph;
    reg [7:0] a;
    begin
      case (ph)
        3'h0: a = 8'h00;
        3'h1: a = 8'h31;
        3'h2: a = 8'h5A;
        3'h3: a = 8'h75;
        3'h4: a = 8'h7F;
        3'h5: a = 8'h75;
        3'h6: a = 8'h5A;
        default: a = 8'h31;
      endcase
      shape = chip ? a : 8'h00 - a;
    end
  endfunction

  // Bus decode; zero wait states, read data registered in setup
  wire setup_rd = psel & ~penable & ~pwrite;
  wire acc_rd = psel & penable & ~pwrite;
  wire wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  wire on_req = wr & (paddr == `CMD_ADDR) & ~pwdata[`CMD_ON_BIT];
  wire off_req = wr & (paddr == `CMD_ADDR) & ~pwdata[`CMD_OFF_BIT];
  wire modem_ready = (mstate == M_READY);
  wire tx_busy = (tstate != T_IDLE);
  wire rx_busy = (rstate != R_HUNT);
  wire chan_busy = (rssi_live >= cca_thr);
  wire tx_go = wr & (paddr == `TX_CTRL_ADDR) & pwdata[`TX_GO_BIT] & modem_ready & ~tx_busy & ~rx_busy;
  wire rd_clear = acc_rd & ((paddr == `FLAGS_ADDR) | (paddr == `INDEX_ADDR));
  wire [3:0] pend = flags & ~mask;
  assign irq = |pend;
  assign rf_enable = ~mstate[0];

  // Fixed priority encoder for the index register
  always @* begin
    if (pend[`EV_RX_DONE]) begin
      code = 3'h1;
    end else if (pend[`EV_RX_BEGIN]) begin
      code = 3'h2;
    end else if (pend[`EV_TX_DONE]) begin
      code = 3'h3;
    end else if (pend[`EV_READY]) begin
      code = 3'h4;
    end else begin
      code = 3'h0;
    end
  end

  // Read multiplexer, every register one aligned word
  always @* begin
    hit = 1'b1;
    rdata = 32'h00000000;
    case (paddr)
      `CMD_ADDR: rdata = {24'h000000, 1'b1, mstate != M_WAKE, `CMD_LOW_BITS};
      `CCA_THR_ADDR: rdata = {24'h000000, cca_thr};
      `MASK_ADDR: rdata = {24'h000000, `MASK_HIGH_BITS, mask};
      `INDEX_ADDR: rdata = {24'h000000, pend, 1'b0, code};
      `FLAGS_ADDR: rdata = {28'h0000000, flags};
      `RSSI_PKT_ADDR: rdata = {24'h000000, rssi_pkt};
      `RSSI_LIVE_ADDR: rdata = {24'h000000, rssi_live};
      `TX_CTRL_ADDR: rdata = {29'h00000000, chan_busy, rx_busy, tx_busy};
      default: hit = 1'b0;
    endcase
  end

  // Register file; snapshot lets a read clear only the flags set at its setup
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      snap <= 4'h0;
      mask <= `MASK_RESET;
      cca_thr <= `CCA_THR_RESET;
      flags <= 4'h0;
    end else begin
      if (setup_rd) begin
        prdata <= rdata;
        snap <= flags;
      end
      if (wr & (paddr == `MASK_ADDR)) begin
        mask <= pwdata[3:0];
      end
      if (wr & (paddr == `CCA_THR_ADDR)) begin
        cca_thr <= pwdata[7:0];
      end
      // New events win over a clearing read in the same cycle
      flags <= (flags & ~(rd_clear ? snap : 4'h0))
        | {rx_done_ev, rx_begin_ev, tx_done_ev, ready_ev};
    end
  end

  // Modem power state; starts idle, waits for RF to settle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mstate <= M_IDLE;
      settle <= 16'h0000;
      ready_ev <= 1'b0;
    end else begin
      ready_ev <= 1'b0;
      if (off_req) begin
        mstate <= M_IDLE;
      end else begin
        case (mstate)
          M_IDLE: begin
            settle <= 16'h0000;
            if (on_req) begin
              mstate <= M_WAKE;
            end
          end
          M_WAKE: begin
            settle <= settle + 16'h0001;
            if (settle == SETTLE_CYCLES[15:0] - 16'h0001) begin
              mstate <= M_READY;
              ready_ev <= 1'b1;
            end
          end
          M_READY: mstate <= M_READY;
          default: mstate <= M_IDLE;
        endcase
      end
    end
  end

  // Sample-rate enable
  wire tick = (div == SAMPLE_DIV[7:0] - 8'h01);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 8'h00;
    end else begin
      div <= tick ? 8'h00 : div + 8'h01;
    end
  end

  // Current chip of the current symbol, low nibble first
  wire [31:0] cur_seq = chip_seq(nib ? cur_byte[7:4] : cur_byte[3:0]);
  wire cbit = cur_seq[~chip_idx];
  wire i_now = (sph == 3'h0) ? cbit : ichip;
  wire q_now = (sph == 3'h4) ? cbit : qchip;
  wire [7:0] next_bcnt = bcnt + 8'h01;
  wire [7:0] last_byte = `FIFO_START + {1'b0, tx_len};
  assign tx_fifo_pop = (tstate == T_FETCH) & tx_fifo_valid;

  // Transmitter: even chips on I, odd chips on Q half a pulse later
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tstate <= T_IDLE;
      sph <= 3'h0;
      chip_idx <= 5'h00;
      nib <= 1'b0;
      bcnt <= 8'h00;
      cur_byte <= `PREAMBLE_BYTE;
      tx_len <= 7'h00;
      ichip <= 1'b0;
      qchip <= 1'b0;
      dac_i <= 8'h00;
      dac_q <= 8'h00;
      dac_valid <= 1'b0;
      tx_done_ev <= 1'b0;
    end else begin
      dac_valid <= 1'b0;
      tx_done_ev <= 1'b0;
      if (~modem_ready) begin
        tstate <= T_IDLE;
        dac_i <= 8'h00;
        dac_q <= 8'h00;
      end else begin
        case (tstate)
          T_IDLE: begin
            dac_i <= 8'h00;
            dac_q <= 8'h00;
            if (tx_go) begin
              tstate <= T_CCA;
            end
          end
          T_CCA: begin
            sph <= 3'h0;
            chip_idx <= 5'h00;
            nib <= 1'b0;
            bcnt <= 8'h00;
            cur_byte <= `PREAMBLE_BYTE;
            if (~chan_busy & ~rx_busy) begin
              tstate <= T_SEND;
            end
          end
          T_SEND: begin
            if (tick) begin
              if (sph == 3'h0) begin
                ichip <= cbit;
              end
              if (sph == 3'h4) begin
                qchip <= cbit;
              end
              dac_i <= shape(i_now, sph);
              dac_q <= shape(q_now, sph ^ 3'h4);
              dac_valid <= 1'b1;
              sph <= sph + 3'h1;
              if (sph[1:0] == 2'h3) begin
                chip_idx <= chip_idx + 5'h01;
                if (chip_idx == 5'h1F) begin
                  nib <= ~nib;
                  if (nib) begin
                    if (bcnt == last_byte) begin
                      tstate <= T_DONE;
                    end else begin
                      bcnt <= next_bcnt;
                      if (next_bcnt == `SFD_POS) begin
                        cur_byte <= `SFD_BYTE;
                      end else if (next_bcnt == `FIFO_START || next_bcnt > `FIFO_START) begin
                        tstate <= T_FETCH;
                      end
                    end
                  end
                end
              end
            end
          end
          // Fetch falls between sample ticks; an empty FIFO stalls the carrier
          T_FETCH: begin
            if (tx_fifo_valid) begin
              cur_byte <= tx_fifo_data;
              if (bcnt == `FIFO_START) begin
                tx_len <= tx_fifo_data[6:0];
              end
              tstate <= T_SEND;
            end
          end
          T_DONE: begin
            tx_done_ev <= 1'b1;
            tstate <= T_IDLE;
          end
          default: tstate <= T_IDLE;
        endcase
      end
    end
  end

  // Receiver: delimiter search, then nibble pairs into bytes
  wire rx_on = modem_ready & ~tx_busy;
  wire [7:0] rx_byte = {demod_sym, low_nib};
  wire sfd_hit = rx_on & (rstate == R_HUNT) & demod_sym_valid
    & (prev_sym == `SFD_LOW) & (demod_sym == `SFD_HIGH);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstate <= R_HUNT;
      prev_sym <= 4'h0;
      low_nib <= 4'h0;
      rnib <= 1'b0;
      rx_len <= 7'h00;
      rcnt <= 7'h00;
      rx_fifo_data <= 8'h00;
      rx_fifo_write <= 1'b0;
      rx_begin_ev <= 1'b0;
      rx_done_ev <= 1'b0;
    end else begin
      rx_fifo_write <= 1'b0;
      rx_begin_ev <= 1'b0;
      rx_done_ev <= 1'b0;
      if (~rx_on) begin
        rstate <= R_HUNT;
        prev_sym <= 4'h0;
      end else if (demod_sym_valid) begin
        case (rstate)
          R_HUNT: begin
            prev_sym <= demod_sym;
            rnib <= 1'b0;
            if (sfd_hit) begin
              rx_begin_ev <= 1'b1;
              rstate <= R_LEN;
            end
          end
          R_LEN, R_BODY: begin
            rnib <= ~rnib;
            if (~rnib) begin
              low_nib <= demod_sym;
            end else begin
              rx_fifo_data <= rx_byte;
              rx_fifo_write <= 1'b1;
              rcnt <= rcnt + 7'h01;
              if (rstate == R_LEN) begin
                rx_len <= rx_byte[6:0];
                rcnt <= 7'h00;
                rstate <= R_BODY;
              end
              if ((rstate == R_LEN && rx_byte[6:0] == 7'h00)
                  || (rstate == R_BODY && rcnt + 7'h01 == rx_len)) begin
                rx_done_ev <= 1'b1;
                rstate <= R_HUNT;
                prev_sym <= 4'h0;
              end
            end
          end
          default: rstate <= R_HUNT;
        endcase
      end
    end
  end

  // Power averaging over a window of 2^RSSI_WIN_LOG samples
  wire [RSSI_WIN_LOG+7:0] sum = acc + {{RSSI_WIN_LOG{1'b0}}, rx_power};
  wire [7:0] avg = sum[RSSI_WIN_LOG+7:RSSI_WIN_LOG];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc <= {(RSSI_WIN_LOG+8){1'b0}};
      wcnt <= {RSSI_WIN_LOG{1'b0}};
      rssi_pkt <= 8'h00;
      rssi_live <= 8'h00;
      pkt_latched <= 1'b0;
    end else if (sfd_hit) begin
      // Restart so the packet value covers packet samples only
      acc <= {(RSSI_WIN_LOG+8){1'b0}};
      wcnt <= {RSSI_WIN_LOG{1'b0}};
      pkt_latched <= 1'b0;
    end else if (rx_power_valid) begin
      wcnt <= wcnt + {{(RSSI_WIN_LOG-1){1'b0}}, 1'b1};
      if (&wcnt) begin
        acc <= {(RSSI_WIN_LOG+8){1'b0}};
        if (~rx_busy) begin
          rssi_live <= avg;
        end else if (~pkt_latched) begin
          rssi_pkt <= avg;
          pkt_latched <= 1'b1;
        end
      end else begin
        acc <= sum;
      end
    end
  end

endmodule
`default_nettype wire

// ---- inc/modem_regs.vh ----
`ifndef MODEM_REGS_VH
`define MODEM_REGS_VH

// Register indices; byte address is four times the index
`define CMD_IDX 16'h2200
`define CCA_THR_IDX 16'h2248
`define MASK_IDX 16'h2277
`define INDEX_IDX 16'h2278
`define FLAGS_IDX 16'h227E
`define RSSI_PKT_IDX 16'h2290
`define RSSI_LIVE_IDX 16'h2291
`define TX_CTRL_IDX 16'h2292
`define CMD_ADDR (`CMD_IDX << 2)
`define CCA_THR_ADDR (`CCA_THR_IDX << 2)
`define MASK_ADDR (`MASK_IDX << 2)
`define INDEX_ADDR (`INDEX_IDX << 2)
`define FLAGS_ADDR (`FLAGS_IDX << 2)
`define RSSI_PKT_ADDR (`RSSI_PKT_IDX << 2)
`define RSSI_LIVE_ADDR (`RSSI_LIVE_IDX << 2)
`define TX_CTRL_ADDR (`TX_CTRL_IDX << 2)

// Field positions
`define CMD_OFF_BIT 7
`define CMD_ON_BIT 6
`define TX_GO_BIT 0
`define EV_RX_DONE 3
`define EV_RX_BEGIN 2
`define EV_TX_DONE 1
`define EV_READY 0

// Reset values
`define MASK_RESET 4'h0
`define CCA_THR_RESET 8'h50
`define CMD_LOW_BITS 6'h3C
`define MASK_HIGH_BITS 4'hF

// Frame layout
`define SFD_BYTE 8'hA7
`define SFD_LOW 4'h7
`define SFD_HIGH 4'hA
`define SFD_POS 8'h04
`define FIFO_START 8'h05
`define PREAMBLE_BYTE 8'h00

// Spreading: symbol 0 with C0 at bit 31, odd-chip inversion mask
`define CHIP_BASE 32'hD9C3522E
`define CHIP_ODD_MASK 32'h55555555

// Timing
`define CLK_PERIOD_NS 10
`define RF_SETTLE_NS 20000

`endif

// ---- verification/mac_rf_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mac_rf_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Transmit FIFO head
  output logic [7:0] tx_fifo_data,
  output logic tx_fifo_valid,
  input wire logic tx_fifo_pop,
  // Receive FIFO sink
  input wire logic [7:0] rx_fifo_data,
  input wire logic rx_fifo_write,
  // Demodulator and power
  output logic [3:0] demod_sym,
  output logic demod_sym_valid,
  output logic [7:0] rx_power,
  output logic rx_power_valid
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] level = 8'h00;

  initial begin
    demod_sym = 4'h0;
    demod_sym_valid = 1'b0;
  end

  // FIFO pop and capture; an empty head toggles so no stale byte is reused
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_fifo_valid <= 1'b0;
      tx_fifo_data <= 8'h00;
      rx_power <= 8'h00;
      rx_power_valid <= 1'b0;
    end else begin
      if (tx_fifo_pop && txq.size() != 0) begin
        void'(txq.pop_front());
      end
      tx_fifo_valid <= txq.size() != 0;
      tx_fifo_data <= (txq.size() != 0) ? txq[0] : ~tx_fifo_data;
      rx_power <= level;
      rx_power_valid <= 1'b1;
      if (rx_fifo_write) begin
        rxq.push_back(rx_fifo_data);
      end
    end
  end

  // One symbol per two clocks; gap shows the inverse nibble
  task automatic sym(input logic [3:0] s);
    @(posedge clk);
    demod_sym <= s;
    demod_sym_valid <= 1'b1;
    @(posedge clk);
    demod_sym <= ~s;
    demod_sym_valid <= 1'b0;
  endtask

  // Delimiter then bytes, low nibble first
  task automatic frame(input logic [7:0] q[$]);
    sym(4'h7);
    sym(4'hA);
    foreach (q[k]) begin
      sym(q[k][3:0]);
      sym(q[k][7:4]);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/modem_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "modem_regs.vh"

module modem_asserts #(
  parameter SAMPLE_DIV = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Data paths
  input wire logic tx_fifo_valid,
  input wire logic tx_fifo_pop,
  input wire logic [7:0] dac_i,
  input wire logic [7:0] dac_q,
  input wire logic dac_valid,
  input wire logic [3:0] demod_sym,
  input wire logic demod_sym_valid,
  input wire logic [7:0] rx_fifo_data,
  input wire logic rx_fifo_write,
  input wire logic rf_enable
);
  logic [7:0] gap;
  wire acc = psel && penable;
  wire cmd_wr = acc && pwrite && paddr == `CMD_ADDR;

  // Cycles since last sample; saturates so long idle never wraps
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 8'hFF;
    end else if (dac_valid) begin
      gap <= 8'h00;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Bus answers
  zero_wait_a: assert property (acc |-> pready)
    else $error("access without ready");
  unmapped_word_a: assert property (pslverr |-> acc && (pwrite || prdata == 32'h0))
    else $error("bad error response");
  // Modem power state
  rf_hold_a: assert property (!rf_enable && !cmd_wr |=> !rf_enable)
    else $error("rf woke without request");
  rf_wake_a: assert property (cmd_wr && pwdata[7:6] == 2'b10 |=> rf_enable)
    else $error("on request ignored");
  idle_quiet_a: assert property (!rf_enable |-> !rx_fifo_write && !tx_fifo_pop)
    else $error("traffic while idle");
  dac_idle_a: assert property (!rf_enable |-> !dac_valid && dac_i == 8'h00 && dac_q == 8'h00)
    else $error("dac active while idle");
  // Sample stream and FIFO traffic
  dac_pulse_a: assert property (dac_valid |=> !dac_valid [*8])
    else $error("samples too close");
  sample_gap_a: assert property (dac_valid && gap != 8'hFF |-> gap >= SAMPLE_DIV - 1)
    else $error("sample spacing short");
  pop_valid_a: assert property (tx_fifo_pop |-> tx_fifo_valid)
    else $error("pop from empty fifo");
  rx_write_a: assert property (rx_fifo_write |-> $past(demod_sym_valid) && rx_fifo_data[7:4] == $past(demod_sym))
    else $error("rx byte not from symbols");
endmodule

bind oqpsk_modem modem_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.clk, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fifo_valid, .tx_fifo_pop, .dac_i, .dac_q, .dac_valid,
  .demod_sym, .demod_sym_valid, .rx_fifo_data, .rx_fifo_write, .rf_enable);
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "modem_regs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t %h %h", $time, (a), (b)); end end

module tb;
  typedef struct packed {logic wr; logic [15:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  // Standard chip table, C0 in bit 31
  logic [31:0] chip_tab [16] = '{32'hD9C3522E, 32'hED9C3522, 32'h2ED9C352, 32'h22ED9C35,
    32'h522ED9C3, 32'h3522ED9C, 32'hC3522ED9, 32'h9C3522ED, 32'h8C96077B, 32'hB8C96077, 32'h7B8C9607,
    32'h77B8C960, 32'h077B8C96, 32'h6077B8C9, 32'h96077B8C, 32'hC96077B8};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, tx_fifo_pop, dac_valid, rx_fifo_write, rf_enable, er;
  logic tx_fifo_valid, demod_sym_valid, rx_power_valid;
  logic [7:0] tx_fifo_data, dac_i, dac_q, rx_power, rx_fifo_data;
  logic [3:0] demod_sym;
  logic mon = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int n = 0;
  int i;
  logic [7:0] frm [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'h01, 8'h3C};
  row_t rows [12] = '{
    '{1'b0, `CMD_ADDR, 32'h0, 32'hFC, 1'b0},
    '{1'b0, `MASK_ADDR, 32'h0, 32'hF0, 1'b0},
    '{1'b0, `FLAGS_ADDR, 32'h0, 32'h0, 1'b0},
    '{1'b0, `INDEX_ADDR, 32'h0, 32'h0, 1'b0},
    '{1'b0, `CCA_THR_ADDR, 32'h0, 32'h50, 1'b0},
    '{1'b1, `TX_CTRL_ADDR, 32'h1, 32'h0, 1'b0},
    '{1'b0, `TX_CTRL_ADDR, 32'h0, 32'h0, 1'b0},
    '{1'b1, `MASK_ADDR, 32'hA, 32'h0, 1'b0},
    '{1'b0, `MASK_ADDR, 32'h0, 32'hFA, 1'b0},
    '{1'b1, `MASK_ADDR, 32'h0, 32'h0, 1'b0},
    '{1'b0, 16'h0004, 32'h0, 32'h0, 1'b1},
    '{1'b1, 16'h0008, 32'h1, 32'h0, 1'b1}
  };

  always #5 clk = ~clk;

  oqpsk_modem #(.SETTLE_CYCLES(10)) u_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .tx_fifo_data, .tx_fifo_valid, .tx_fifo_pop, .dac_i, .dac_q, .dac_valid,
    .demod_sym, .demod_sym_valid, .rx_power, .rx_power_valid, .rx_fifo_data, .rx_fifo_write, .rf_enable);

  mac_rf_model u_mac (.clk, .nrst, .tx_fifo_data, .tx_fifo_valid, .tx_fifo_pop, .rx_fifo_data,
    .rx_fifo_write, .demod_sym, .demod_sym_valid, .rx_power, .rx_power_valid);

  // Expected chip g of the frame, looked up in the literal table
  function automatic logic chip(input int g);
    logic [3:0] s;
    logic [31:0] w;
    s = ((g / 32) % 2) ? frm[g / 64][7:4] : frm[g / 64][3:0];
    w = chip_tab[s];
    return w[31 - g % 32];
  endfunction

  // Half-sine peaks carry the chip sign; Q peaks lag by four samples
  always @(posedge clk) begin
    if (mon && dac_valid) begin
      if (n % 8 == 4) `CHK({dac_i[7], dac_i == 8'h00}, {~chip(2 * (n / 8)), 1'b0})
      if (n % 8 == 0 && n >= 8) `CHK({dac_q[7], dac_q == 8'h00}, {~chip(2 * (n / 8) - 1), 1'b0})
      n <= n + 1;
    end
  end

  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      close_out;
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rd, x)
  endtask

  task automatic rxchk(input logic [7:0] ex[$]);
    repeat (2) @(posedge clk);
    `CHK(u_mac.rxq.size(), ex.size())
    foreach (ex[k]) `CHK(u_mac.rxq[k], ex[k])
    u_mac.rxq.delete();
  endtask

  // Bounded wait for a sample count
  task automatic upto(input int c);
    i = 0;
    while (n < c && i < 30000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 30000) begin
      miscompares++;
      close_out;
    end
  endtask

  initial begin
    #600000;
    miscompares++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[r]) begin
      apb(rows[r].wr, rows[r].a, rows[r].d);
      `CHK(er, rows[r].e)
      if (!rows[r].wr) `CHK(rd, rows[r].x)
    end
    `CHK(rf_enable, 1'b0)
    // Wake up: bit 6 low while settling, then the ready event
    apb(1'b1, `CMD_ADDR, 32'hBF);
    rdchk(`CMD_ADDR, 32'hBC);
    i = 0;
    while (irq !== 1'b1 && i < 50) begin
      @(posedge clk);
      i++;
    end
    if (i >= 50) begin
      miscompares++;
      close_out;
    end
    `CHK(i inside {[7:10]}, 1'b1)
    rdchk(`INDEX_ADDR, 32'h14);
    @(negedge clk);
    `CHK(irq, 1'b0)
    rdchk(`CMD_ADDR, 32'hFC);
    // Frame in: both rx flags pending together, rx end wins the index
    u_mac.level = 8'h30;
    u_mac.frame({8'h03, 8'h5A, 8'hC3, 8'h81});
    rxchk({8'h03, 8'h5A, 8'hC3, 8'h81});
    `CHK(irq, 1'b1)
    rdchk(`INDEX_ADDR, 32'hC1);
    rdchk(`FLAGS_ADDR, 32'h0);
    rdchk(`RSSI_PKT_ADDR, 32'h30);
    // Packet strength held while the live value moves
    u_mac.level = 8'h10;
    repeat (30) @(posedge clk);
    rdchk(`RSSI_LIVE_ADDR, 32'h10);
    rdchk(`RSSI_PKT_ADDR, 32'h30);
    // Empty body with rx end masked
    apb(1'b1, `MASK_ADDR, 32'h8);
    u_mac.frame({8'h00});
    rxchk({8'h00});
    `CHK(irq, 1'b1)
    rdchk(`FLAGS_ADDR, 32'h0C);
    @(negedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, `MASK_ADDR, 32'h4);
    // Transmit deferred by a busy channel, a second go ignored
    u_mac.txq = {8'h01, 8'h3C};
    u_mac.level = 8'hFF;
    repeat (30) @(posedge clk);
    mon <= 1'b1;
    apb(1'b1, `TX_CTRL_ADDR, 32'h1);
    repeat (40) @(posedge clk);
    `CHK(n, 0)
    rdchk(`TX_CTRL_ADDR, 32'h5);
    u_mac.level = 8'h10;
    upto(300);
    apb(1'b1, `TX_CTRL_ADDR, 32'h1);
    upto(1792);
    `CHK(n, 1792)
    `CHK(u_mac.txq.size(), 0)
    repeat (3) @(posedge clk);
    rdchk(`INDEX_ADDR, 32'h23);
    repeat (200) @(posedge clk);
    `CHK(n, 1792)
    rdchk(`TX_CTRL_ADDR, 32'h0);
    // Reset in mid-run returns to idle
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    `CHK(rf_enable, 1'b0)
    rdchk(`CMD_ADDR, 32'hFC);
    close_out;
  end
endmodule
`default_nettype wire
